// ===== rtl/usc_pkg.sv
// Purpose: shared constants and types of the serial status/control block
// Assumes: 20 MHz aclk, fixed bit rate, 8 data bits, no parity
// Notes: offsets are AXI4-Lite byte addresses
// Notes on behaviour
// - mode 10: irq when load empties buffer
// - mode 01: irq when all sending finished
// - mode 00: irq on every load into shifter
// - plain line idles high, low when inverted
// - infrared line idles low, high when inverted
// - break sends start, twelve zeros, stop; self-clears
// - enabled transmitter drives and owns the pin
// - disable aborts, flushes buffer, releases pin
// - full flag reads 1 when buffer full
// - shift empty only when shifter and buffer empty
// - receive mode 11: irq at four characters
// - receive mode 10: irq at three characters
// - receive mode 0x: irq on every character
package usc_pkg;
    // bit timing from clock and bit rate
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned BAUD_HZ = 1_250_000;
    localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_HZ;
    localparam logic [4:0] BIT_LAST = 5'(BIT_CYCLES - 1);
    localparam logic [4:0] HALF_LAST = 5'(BIT_CYCLES / 2 - 1);
    localparam logic [4:0] IR_PULSE = 5'(BIT_CYCLES * 3 / 16);
    localparam logic [3:0] DATA_LAST = 4'h7;
    localparam logic [3:0] BREAK_LAST = 4'hB;
    localparam logic [2:0] BUF_FULL = 3'h4;
    localparam logic [2:0] BUF_3Q = 3'h3;
    // register byte offsets
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_TXDATA = 8'h04;
    localparam logic [7:0] OFF_RXDATA = 8'h08;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFF_LINE_CTRL = 8'h14;
    // field positions of serial_status_control and of the irq status/mask bits
    localparam int POS_TX_MODE_HI = 15;
    localparam int POS_TX_INVERT = 14;
    localparam int POS_TX_MODE_LO = 13;
    localparam int POS_TX_BREAK = 11;
    localparam int POS_TX_ENABLE = 10;
    localparam int POS_RX_MODE_LO = 6;
    localparam int POS_ADDR_DETECT = 5;
    localparam int POS_OVERRUN = 1;
    localparam int POS_IRQ_TX = 0;
    localparam int POS_IRQ_RX = 1;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {TXM_EACH = 2'b00, TXM_DONE = 2'b01, TXM_EMPTY = 2'b10, TXM_RSVD = 2'b11} usc_txm_t;
    typedef enum logic [1:0] {LN_IDLE = 2'b00, LN_START = 2'b01, LN_DATA = 2'b10, LN_STOP = 2'b11} usc_ln_t;
endpackage : usc_pkg

// ===== rtl/usc_ifs.sv
// Purpose: carriers from the top to its buffer and receiver
// Assumes: all signals on aclk
// Notes: owner side requests, store/engine side answers
interface usc_buf_if;
    logic push; // write one character
    logic [7:0] push_data; // character written
    logic pop; // drop the head character
    logic flush; // empty the buffer
    logic [7:0] head; // oldest character
    logic [2:0] count; // characters held
    modport owner (output push, push_data, pop, flush, input head, count);
    modport store (input push, push_data, pop, flush, output head, count);
endinterface : usc_buf_if

interface usc_rx_if;
    logic pop; // software read of the oldest character
    logic [1:0] mode; // receive interrupt mode
    logic overrun_clear; // software wrote zero to overrun
    logic [7:0] data; // oldest character
    logic available; // at least one character held
    logic idle; // receiver between characters
    logic framing; // last character had a bad stop bit
    logic overrun; // sticky overrun
    logic rx_event; // one-cycle receive interrupt event
    modport host (output pop, mode, overrun_clear, input data, available, idle, framing, overrun, rx_event);
    modport engine (input pop, mode, overrun_clear, output data, available, idle, framing, overrun, rx_event);
endinterface : usc_rx_if

// ===== rtl/usc_buf.sv
// Purpose: four-character transmit buffer
// Assumes: owner never pops an empty buffer
// Notes: flush wins over push and pop
module usc_buf
    import usc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    usc_buf_if.store b
);
    typedef struct packed {
        logic [3:0][7:0] mem;
        logic [1:0] rd;
        logic [1:0] wr;
        logic [2:0] count;
    } usc_buf_t;
    usc_buf_t r; // registered state
    usc_buf_t n; // next state
    // pointer and count update
    always_comb begin
        n = r;
        if (b.flush) begin
            n = '0;
        end else begin
            if (b.pop) begin
                n.rd = r.rd + 2'h1;
            end
            if (b.push) begin
                n.mem[r.wr] = b.push_data;
                n.wr = r.wr + 2'h1;
            end
            n.count = r.count + {2'h0, b.push} - {2'h0, b.pop};
        end
    end
    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
    assign b.head = r.mem[r.rd];
    assign b.count = r.count;
endmodule : usc_buf

// ===== rtl/usc_rx.sv
// Purpose: receiver with four-character buffer and flags
// Assumes: 8 data bits, 1 stop bit, line idles high
// Notes: a character arriving when full is dropped unless a read pops in the same cycle
module usc_rx
    import usc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic rx_line,
    usc_rx_if.engine x
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        usc_ln_t state;
        logic [4:0] tick;
        logic [2:0] bit_idx;
        logic [7:0] shifter;
        logic [3:0][7:0] mem;
        logic [1:0] rd;
        logic [1:0] wr;
        logic [2:0] count;
        logic framing;
        logic overrun;
        logic rx_event;
    } usc_rx_t;
    localparam usc_rx_t RX_RESET = '{sync1: 1'h1, sync2: 1'h1, state: LN_IDLE, default: '0};
    usc_rx_t r; // registered state
    usc_rx_t n; // next state
    logic pop; // accepted read
    logic put;  // accepted character
    always_comb begin
        n = r;
        put = 1'h0;
        pop = x.pop && (r.count != 3'h0);
        n.rx_event = 1'h0;
        n.sync1 = rx_line;
        n.sync2 = r.sync1;
        n.tick = r.tick + 5'h1;
        case (r.state)
            LN_IDLE: begin
                n.tick = 5'h0;
                if (!r.sync2) n.state = LN_START;
            end
            LN_START: if (r.tick == HALF_LAST) begin
                n.tick = 5'h0;
                n.bit_idx = 3'h0;
                n.state = r.sync2 ? LN_IDLE : LN_DATA; // reject a glitch
            end
            LN_DATA: if (r.tick == BIT_LAST) begin
                n.tick = 5'h0;
                n.shifter = {r.sync2, r.shifter[7:1]};
                n.bit_idx = r.bit_idx + 3'h1;
                if (r.bit_idx == 3'h7) n.state = LN_STOP;
            end
            LN_STOP: if (r.tick == BIT_LAST) begin
                n.state = LN_IDLE;
                n.framing = !r.sync2;
                put = (r.count != BUF_FULL) || pop;
                if (!put) n.overrun = 1'h1;
            end
            default: n.state = LN_IDLE;
        endcase
        if (x.overrun_clear && !(r.state == LN_STOP && r.tick == BIT_LAST && !put)) begin
            n.overrun = 1'h0;
        end
        if (pop) n.rd = r.rd + 2'h1;
        if (put) begin
            n.mem[r.wr] = r.shifter;
            n.wr = r.wr + 2'h1;
        end
        n.count = r.count + {2'h0, put} - {2'h0, pop};
        if (put) begin
            case (x.mode)
                2'b11: n.rx_event = (n.count == BUF_FULL);
                2'b10: n.rx_event = (n.count == BUF_3Q);
                default: n.rx_event = 1'h1;
            endcase
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) r <= RX_RESET;
        else r <= n;
    end
    assign x.data = r.mem[r.rd];
    assign x.available = (r.count != 3'h0);
    assign x.idle = (r.state == LN_IDLE);
    assign x.framing = r.framing;
    assign x.overrun = r.overrun;
    assign x.rx_event = r.rx_event;
endmodule : usc_rx

// ===== rtl/usc_top.sv
// Purpose: serial port status/control block with AXI4-Lite registers
// Assumes: single clock aclk, synchronous active-low reset
// Notes: transmit engine here; receiver and buffer are submodules
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
module usc_top
    import usc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rx_line,
    output logic tx_line_out,
    output logic tx_line_oe,
    output logic irq
);
    // all flip-flops of the top in one record
    typedef struct packed {
        // bus side
        logic aw_held; // write address waiting
        logic [7:0] aw_addr;
        logic w_held; // write data waiting
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        // software control fields
        logic [1:0] tx_irq_mode;
        logic tx_polarity_invert;
        logic tx_break_request;
        logic tx_enable_bit;
        logic [1:0] rx_irq_mode;
        logic address_detect_enable;
        logic infrared_encode_enable;
        logic [1:0] irq_status; // sticky events
        logic [1:0] irq_mask;
        // transmit engine
        usc_ln_t state;
        logic [4:0] tick; // cycle within the current bit
        logic [3:0] bit_idx; // bit within data or break field
        logic [7:0] shifter; // transmit shift register
        logic is_break; // current frame is a sync break
        logic line_out; // registered pin level
    } usc_top_t;

    // line idles high: inversion starts clear; responses reset to okay
    localparam usc_top_t TOP_RESET = '{irq_mask: IRQ_MASK_RESET,
                                       state: LN_IDLE, line_out: 1'h1, default: '0};

    usc_top_t r; // registered state
    usc_top_t n; // next state

    usc_buf_if txb(); // transmit buffer carrier
    usc_rx_if rxi(); // receiver carrier

    logic do_write; // both write halves held, answer slot free
    logic do_read; // read address taken this edge
    logic tx_load; // head character moves into the shifter
    logic tx_full; // buffer cannot take another character
    logic tx_shift_empty; // nothing sent or queued
    logic [2:0] tx_cnt_next; // buffer fill after this edge
    logic [15:0] status_word; // serial_status_control as read
    logic tx_event; // transmit interrupt event
    logic brk_done; // sync break finished this edge
    logic zero_bit; // raw line bit about to be sent is zero
    logic ir_pulse; // infrared pulse active

    // word compare, low address bits ignored
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction : hit

    // registers fill consecutive words from zero up to line control
    function automatic logic mapped(input logic [7:0] a);
        return a[7:2] <= OFF_LINE_CTRL[7:2];
    endfunction : mapped

    // transmit character buffer
    usc_buf u_txbuf (
        .aclk(aclk),
        .aresetn(aresetn),
        .b(txb)
    );

    // receive engine with its own buffer
    usc_rx u_rx (
        .aclk(aclk),
        .aresetn(aresetn),
        .rx_line(rx_line),
        .x(rxi)
    );

    // one write and one read in flight
    assign s_axi_awready = !r.aw_held && !r.bvalid;
    assign s_axi_wready = !r.w_held && !r.bvalid;
    assign s_axi_arready = !r.rvalid;
    assign do_write = r.aw_held && r.w_held && !r.bvalid;
    assign do_read = s_axi_arvalid && !r.rvalid;

    // buffer flags seen by software
    assign tx_full = (txb.count == BUF_FULL);
    assign tx_shift_empty = (r.state == LN_IDLE) && (txb.count == 3'h0);

    // writes while full or disabled are dropped
    assign txb.push = do_write && hit(r.aw_addr, OFF_TXDATA) && r.w_strb[0] && r.tx_enable_bit && !tx_full;
    assign txb.push_data = r.w_data[7:0];
    assign tx_load = r.tx_enable_bit && (r.state == LN_IDLE) && (txb.count != 3'h0);
    assign txb.pop = tx_load;
    assign txb.flush = !r.tx_enable_bit;
    assign tx_cnt_next = txb.count + {2'h0, txb.push} - {2'h0, tx_load};

    // receiver controls; a data read pops
    assign rxi.pop = do_read && hit(s_axi_araddr, OFF_RXDATA);
    assign rxi.mode = r.rx_irq_mode;
    assign rxi.overrun_clear = do_write && hit(r.aw_addr, OFF_STATUS) && r.w_strb[0] &&
                               !r.w_data[POS_OVERRUN];

    // no parity, so its error flag reads zero
    assign status_word = {r.tx_irq_mode[1], r.tx_polarity_invert, r.tx_irq_mode[0], 1'h0,
                          r.tx_break_request, r.tx_enable_bit, tx_full, tx_shift_empty,
                          r.rx_irq_mode, r.address_detect_enable, rxi.idle, 1'h0,
                          rxi.framing, rxi.overrun, rxi.available};

    // next state of bus, registers and transmitter
    always_comb begin
        n = r;
        tx_event = 1'h0;
        brk_done = 1'h0;

        // transmitter: one bit every BIT_CYCLES clocks
        if (!r.tx_enable_bit) begin
            // abort anything in progress
            n.state = LN_IDLE;
            n.tick = 5'h0;
            n.is_break = 1'h0;
        end else if (tx_load) begin
            n.state = LN_START;
            n.tick = 5'h0;
            n.bit_idx = 4'h0;
            n.shifter = txb.head;
            // with a break pending the character is a dummy
            n.is_break = r.tx_break_request;
            case (r.tx_irq_mode)
                TXM_EACH: tx_event = 1'h1;
                TXM_EMPTY: tx_event = (tx_cnt_next == 3'h0);
                default: tx_event = 1'h0;
            endcase
        end else if (r.state != LN_IDLE) begin
            if (r.tick != BIT_LAST) begin
                n.tick = r.tick + 5'h1;
            end else begin
                n.tick = 5'h0;
                case (r.state)
                    LN_START: n.state = LN_DATA;
                    LN_DATA: begin
                        n.shifter = {1'h0, r.shifter[7:1]};
                        n.bit_idx = r.bit_idx + 4'h1;
                        // break: twelve zeros instead of eight data bits
                        if (r.bit_idx == (r.is_break ? BREAK_LAST : DATA_LAST)) begin
                            n.state = LN_STOP;
                        end
                    end
                    LN_STOP: begin
                        n.state = LN_IDLE;
                        brk_done = r.is_break;
                        n.is_break = 1'h0;
                        if (r.tx_irq_mode == TXM_DONE && tx_cnt_next == 3'h0) begin
                            tx_event = 1'h1;
                        end
                    end
                    default: n.state = LN_IDLE;
                endcase
            end
        end

        // start, data zeros and break bits send zero
        zero_bit = (n.state == LN_START) || (n.state == LN_DATA && (n.is_break || !n.shifter[0]));
        ir_pulse = zero_bit && (n.tick < IR_PULSE);
        if (r.infrared_encode_enable) begin
            // short pulse per zero bit, idle at invert level
            n.line_out = ir_pulse ? !r.tx_polarity_invert : r.tx_polarity_invert;
        end else begin
            n.line_out = zero_bit ? r.tx_polarity_invert : !r.tx_polarity_invert;
        end

        // hardware clear; a same-cycle write wins
        if (brk_done) begin
            n.tx_break_request = 1'h0;
        end

        // address and data captured independently
        if (s_axi_awvalid && s_axi_awready) begin
            n.aw_held = 1'h1;
            n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            n.w_held = 1'h1;
            n.w_data = s_axi_wdata;
            n.w_strb = s_axi_wstrb;
        end
        if (r.bvalid && s_axi_bready) begin
            n.bvalid = 1'h0;
        end

        // register write, byte lanes honoured
        if (do_write) begin
            n.aw_held = 1'h0;
            n.w_held = 1'h0;
            n.bvalid = 1'h1;
            n.bresp = mapped(r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            if (hit(r.aw_addr, OFF_STATUS)) begin
                if (r.w_strb[0]) begin
                    n.rx_irq_mode = r.w_data[POS_RX_MODE_LO +: 2];
                    n.address_detect_enable = r.w_data[POS_ADDR_DETECT];
                end
                if (r.w_strb[1]) begin
                    n.tx_irq_mode = {r.w_data[POS_TX_MODE_HI], r.w_data[POS_TX_MODE_LO]};
                    n.tx_polarity_invert = r.w_data[POS_TX_INVERT];
                    n.tx_break_request = r.w_data[POS_TX_BREAK];
                    n.tx_enable_bit = r.w_data[POS_TX_ENABLE];
                end
            end
            if (hit(r.aw_addr, OFF_IRQ_MASK) && r.w_strb[0]) begin
                n.irq_mask = r.w_data[1:0];
            end
            if (hit(r.aw_addr, OFF_LINE_CTRL) && r.w_strb[0]) begin
                n.infrared_encode_enable = r.w_data[0];
            end
        end

        // sticky events: write one clears, an event wins
        n.irq_status = r.irq_status &
                       ~((do_write && hit(r.aw_addr, OFF_IRQ_STATUS) && r.w_strb[0]) ? r.w_data[1:0] : 2'h0);
        if (tx_event) n.irq_status[POS_IRQ_TX] = 1'h1;
        if (rxi.rx_event) n.irq_status[POS_IRQ_RX] = 1'h1;

        // read data captured on the address edge
        if (r.rvalid && s_axi_rready) begin
            n.rvalid = 1'h0;
        end
        if (do_read) begin
            n.rvalid = 1'h1;
            n.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            n.rdata = 32'h0000_0000;
            if (hit(s_axi_araddr, OFF_STATUS)) begin
                n.rdata[15:0] = status_word;
            end else if (hit(s_axi_araddr, OFF_RXDATA)) begin
                n.rdata[7:0] = rxi.available ? rxi.data : 8'h00;
            end else if (hit(s_axi_araddr, OFF_IRQ_STATUS)) begin
                n.rdata[1:0] = r.irq_status;
            end else if (hit(s_axi_araddr, OFF_IRQ_MASK)) begin
                n.rdata[1:0] = r.irq_mask;
            end else if (hit(s_axi_araddr, OFF_LINE_CTRL)) begin
                n.rdata[0] = r.infrared_encode_enable;
            end
        end
    end

    // single state register, synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= TOP_RESET;
        end else begin
            r <= n;
        end
    end

    // outputs from the state record
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;
    // pin owned only while transmit enabled
    assign tx_line_out = r.line_out;
    assign tx_line_oe = r.tx_enable_bit;
    assign irq = |(r.irq_status & r.irq_mask);
endmodule : usc_top

// ===== tb/usc_chk.sv
// Purpose: bus and pin-ownership checks on the top ports
// Assumes: one write and one read outstanding at a time
// Notes: pin level is checked by the bench
module usc_chk
    import usc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic tx_line_oe
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // both halves of a write taken at one edge
    wire both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    // write to the status enable byte
    wire st_wr = both && s_axi_awaddr[7:2] == 6'h00 && s_axi_wstrb[1];
    wire ar_go = s_axi_arvalid && s_axi_arready;
    a_write_answer: assert property (both |-> ##2 s_axi_bvalid) else $error("write not answered");
    a_read_answer: assert property (ar_go |=> s_axi_rvalid) else $error("read not answered");
    a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
    a_write_slverr: assert property (both && s_axi_awaddr[7:2] > 6'h05 |-> ##2 s_axi_bresp == RESP_SLVERR)
        else $error("unmapped write okay");
    a_read_slverr: assert property (ar_go && s_axi_araddr[7:2] > 6'h05 |=> s_axi_rresp == RESP_SLVERR
        && s_axi_rdata == 32'h0000_0000) else $error("unmapped read okay");
    a_oe_on: assert property (st_wr && s_axi_wdata[10] |-> ##[1:4] tx_line_oe) else $error("pin not owned");
    a_oe_off: assert property (st_wr && !s_axi_wdata[10] |-> ##[1:4] !tx_line_oe) else $error("pin kept");
endmodule : usc_chk

bind usc_top usc_chk chk_i (.*);

// ===== tb/usc_peer.sv
// Purpose: remote serial transceiver on the line side
// Assumes: 16 clocks a bit, 8 data bits lsb first, one stop bit
// Notes: decodes plain non-inverted frames only
module usc_peer (
    input wire logic clk,
    input wire logic tx_line,
    input wire logic tx_oe,
    output logic rx_line,
    output logic [7:0] got
);
    timeunit 1ns;
    timeprecision 1ns;
    initial rx_line = 1'b1; // idles high between frames
    // one frame: start low, data lsb first, stop high
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_line <= f[i];
            repeat (16) @(posedge clk);
        end
    endtask : send
    // sample owned line at mid-bit, start edge arms it
    always begin
        @(negedge tx_line iff tx_oe);
        repeat (8) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (16) @(posedge clk);
            got[i] = tx_line;
        end
        repeat (16) @(posedge clk);
    end
endmodule : usc_peer

// ===== tb/tb.sv
// Purpose: directed bench of the serial status/control block
// Assumes: bready and rready held high, answers waited for
// Notes: rx thresholds use the peer as sender
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
    $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module tb
    import usc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0;
    logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rx_line, tx_line_out, tx_line_oe, irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr, peer_got;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
    int n_fail = 0;
    int check_count = 0;
    usc_top uut (.*);
    usc_peer peer (.clk(aclk), .tx_line(tx_line_out), .tx_oe(tx_line_oe), .rx_line(rx_line), .got(peer_got));
    always #25 aclk = ~aclk;
    // both halves offered, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int t = 0;
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, v, 2'b11};
        do begin
            @(posedge aclk);
            t++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && t < 40);
        if (!s_axi_bvalid) n_fail++;
        last_resp = s_axi_bresp;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
    endtask : rd
    // reset word, unmapped place
    task automatic t_reset;
        rd(OFF_STATUS);
        `CHK(d[15:0], 16'h0110)
        `CHK(tx_line_oe, 1'b0)
        wr(8'h18, 32'hFFFF_FFFF);
        `CHK(last_resp, RESP_SLVERR)
        rd(8'h1C);
        `CHK(d, 32'h0000_0000)
        $display("t_reset done");
    endtask : t_reset
    // modes 00 then 01; irq mask and clear
    task automatic t_tx;
        wr(OFF_IRQ_MASK, 32'h0000_0003);
        wr(OFF_STATUS, 32'h0000_0400);
        `CHK(tx_line_out, 1'b1)
        wr(OFF_TXDATA, 32'h0000_0055);
        repeat (4) @(posedge aclk);
        `CHK(tx_line_out, 1'b0)
        `CHK(irq, 1'b1)
        wr(OFF_IRQ_MASK, 32'h0000_0000);
        `CHK(irq, 1'b0)
        wr(OFF_IRQ_STATUS, 32'h0000_0001);
        wr(OFF_IRQ_MASK, 32'h0000_0003);
        wr(OFF_STATUS, 32'h0000_2400);
        wr(OFF_TXDATA, 32'h0000_0055);
        repeat (100) @(posedge aclk);
        `CHK(irq, 1'b0)
        repeat (220) @(posedge aclk);
        `CHK(irq, 1'b1)
        `CHK(peer_got, 8'h55)
        $display("t_tx done");
    endtask : t_tx
    // mode 10, fill to full, then abort by disable
    task automatic t_full;
        wr(OFF_IRQ_STATUS, 32'h0000_0003);
        wr(OFF_STATUS, 32'h0000_8400);
        for (int i = 0; i < 5; i++) wr(OFF_TXDATA, 32'(i));
        `CHK(irq, 1'b1)
        rd(OFF_STATUS);
        `CHK(d[9:8], 2'b10)
        wr(OFF_STATUS, 32'h0000_0000);
        rd(OFF_STATUS);
        `CHK(d[15:0], 16'h0110)
        `CHK(tx_line_oe, 1'b0)
        $display("t_full done");
    endtask : t_full
    // break low for thirteen bit times, self-clearing
    task automatic t_break;
        wr(OFF_STATUS, 32'h0000_0C00);
        wr(OFF_TXDATA, 32'h0000_0000);
        repeat (200) @(posedge aclk);
        `CHK(tx_line_out, 1'b0)
        repeat (40) @(posedge aclk);
        `CHK(tx_line_out, 1'b1)
        rd(OFF_STATUS);
        `CHK(d[11], 1'b0)
        $display("t_break done");
    endtask : t_break
    // idle level for each {infrared, invert} pair
    task automatic t_pol;
        logic [1:0] cfg [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
        for (int i = 0; i < 4; i++) begin
            wr(OFF_LINE_CTRL, 32'(cfg[i][1]));
            wr(OFF_STATUS, 32'h0000_0400 | (32'(cfg[i][0]) << 14));
            repeat (2) @(posedge aclk);
            `CHK(tx_line_out, ~^cfg[i])
        end
        wr(OFF_LINE_CTRL, 32'h0000_0000);
        $display("t_pol done");
    endtask : t_pol
    // rx thresholds per mode, then drain in order
    task automatic t_rx;
        logic [7:0] m [4] = '{8'h00, 8'h40, 8'h80, 8'hC0};
        int n [4] = '{1, 1, 3, 4};
        for (int k = 0; k < 4; k++) begin
            wr(OFF_STATUS, 32'(m[k]));
            wr(OFF_IRQ_STATUS, 32'h0000_0003);
            for (int j = 0; j < n[k]; j++) begin
                peer.send(8'h30 + 8'(j));
                repeat (4) @(posedge aclk);
                `CHK(irq, (j == n[k] - 1))
            end
            for (int j = 0; j < n[k]; j++) begin
                rd(OFF_RXDATA);
                `CHK(d[7:0], 8'h30 + 8'(j))
            end
        end
        $display("t_rx done");
    endtask : t_rx
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_wstrb, s_axi_bready, s_axi_rready} = '1;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset;
        t_tx;
        t_full;
        t_break;
        t_pol;
        t_rx;
        report_and_stop;
    end
    // hang guard, well past the expected run
    initial begin
        #500_000;
        n_fail++;
        report_and_stop;
    end
endmodule : tb
